// ==== include/cpe_pkg.sv ====
package cpe_pkg;

  // Register pointers
  localparam logic [7:0] PTR_CONFIG = 8'h00;
  localparam logic [7:0] PTR_SHUNT = 8'h01;
  localparam logic [7:0] PTR_BUS = 8'h02;
  localparam logic [7:0] PTR_POWER = 8'h03;
  localparam logic [7:0] PTR_CURRENT = 8'h04;
  localparam logic [7:0] PTR_CAL = 8'h05;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h399f;
  localparam logic [15:0] CAL_RESET = 16'h0000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;

  // Scaling
  localparam int CUR_DIV = 4096;
  localparam int PWR_DIV = 5000;
  localparam int BUS_SHIFT = 3;
  localparam int SHUNT_UV_PER_LSB = 10;
  localparam int BUS_MV_PER_LSB = 4;
  localparam int PWR_LSB_RATIO = 20;

  // Link timing
  localparam int TIMEOUT_MS = 28;
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic soft_rst;
    logic rsvd;
    logic bus_range_32v;
    logic [1:0] shunt_gain_stage;
    logic [3:0] bus_adc;
    logic [3:0] shunt_adc;
    logic [2:0] mode;
  } config_s;

  typedef struct packed {
    logic signed [15:0] shunt;
    logic [15:0] bus;
  } sample_s;

  typedef struct packed {
    logic signed [15:0] current;
    logic [15:0] power;
  } result_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_MACK = 5'b10000
  } link_state_e;

endpackage

// ==== core/power_math.sv ====
`timescale 1ns/1ns
module power_math (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Conversion input
  input wire logic start_in,
  input wire logic cal_valid_in,
  input wire cpe_pkg::sample_s sample_in,
  input wire logic [15:0] cal_in,
  // Results
  output cpe_pkg::result_s result_out,
  output logic done_out
);
  import cpe_pkg::*;

  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_quot;
  logic [15:0] cur_mag;
  logic [28:0] pwr_prod;
  logic [28:0] pwr_quot;
  logic signed [15:0] cur_q, next_cur_q;
  logic [12:0] bus_q, next_bus_q;
  logic stage1, next_stage1;
  logic next_done;
  result_s next_result;

  always_comb begin
    // Signed divide truncates toward zero, unlike an arithmetic shift
    cur_prod = sample_in.shunt * $signed({1'b0, cal_in});
    cur_quot = cur_prod / $signed(33'(CUR_DIV));
    next_cur_q = cal_valid_in ? cur_quot[15:0] : 16'h0000;
    next_bus_q = sample_in.bus[15:BUS_SHIFT];
    if (!start_in) begin
      next_cur_q = cur_q;
      next_bus_q = bus_q;
    end
    // Power is unsigned, so the current magnitude is used
    cur_mag = cur_q[15] ? 16'(-cur_q) : cur_q;
    pwr_prod = cur_mag * bus_q;
    pwr_quot = pwr_prod / 29'(PWR_DIV);
    next_stage1 = start_in;
    next_done = stage1;
    next_result = result_out;
    if (stage1) begin
      next_result.current = cur_q;
      next_result.power = pwr_quot[15:0];
    end
    if (!cal_valid_in) begin
      next_result = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_q <= 16'h0000;
      bus_q <= 13'h0000;
      stage1 <= 1'b0;
      done_out <= 1'b0;
      result_out <= '0;
    end else begin
      cur_q <= next_cur_q;
      bus_q <= next_bus_q;
      stage1 <= next_stage1;
      done_out <= next_done;
      result_out <= next_result;
    end
  end

  current_calc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    start_in && cal_valid_in |=> cur_q == 16'(($signed($past(sample_in.shunt))
      * $signed({1'b0, $past(cal_in)})) / 33'sd4096))
    else $error("current result does not match shunt times calibration over 4096");

  power_calc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    stage1 && cal_valid_in |=> result_out.power
      == 16'((29'($past(cur_mag)) * $past(bus_q)) / 29'd5000))
    else $error("power result does not match current times bus over 5000");

endmodule // power_math

// ==== core/current_power_calc_engine.sv ====
`timescale 1ns/1ns
module current_power_calc_engine #(
  parameter int TIMEOUT_CYCLES = cpe_pkg::TIMEOUT_CYC,
  parameter logic [6:0] DEV_ADDR = cpe_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Serial link pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Converter side
  input wire cpe_pkg::sample_s sample_in,
  input wire logic conv_done_in,
  // Settings and results
  output cpe_pkg::config_s config_out,
  output cpe_pkg::result_s result_out,
  output logic calibrated_out
);
  import cpe_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  logic [1:0] rst_pipe;
  logic rst_n;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det, tout_hit;

  link_state_e state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [1:0] byte_idx, next_byte_idx;
  logic rw, next_rw;
  logic [7:0] ptr, next_ptr;
  logic [7:0] wr_hi, next_wr_hi;
  logic [7:0] rd_lsb, next_rd_lsb;
  logic tx_lsb, next_tx_lsb;
  logic sda_oe, next_sda_oe;
  logic [TW-1:0] tout_cnt, next_tout_cnt;

  config_s cfg, next_cfg;
  logic [15:0] cal, next_cal;
  logic cal_valid, next_cal_valid;
  sample_s samp, next_samp;
  logic [15:0] rd_word;
  logic reg_wr;
  logic [15:0] wr_word;

  // Reset release through two flops
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Pin synchronisers; edges are found on the second stage only
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1, scl_s2, scl_d} <= 3'b111;
      {sda_s1, sda_s2, sda_d} <= 3'b111;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  always_comb begin
    scl_rise = scl_s2 && !scl_d;
    scl_fall = !scl_s2 && scl_d;
    start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
    tout_hit = (state != ST_IDLE) && (tout_cnt == TW'(TIMEOUT_CYCLES - 1));
  end

  // Read mux; unmapped pointers read zero
  always_comb begin
    case (ptr)
      PTR_CONFIG: rd_word = cfg;
      PTR_SHUNT: rd_word = samp.shunt;
      PTR_BUS: rd_word = samp.bus;
      PTR_POWER: rd_word = result_out.power;
      PTR_CURRENT: rd_word = result_out.current;
      PTR_CAL: rd_word = cal;
      default: rd_word = 16'h0000;
    endcase
  end

  // Link state machine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_byte_idx = byte_idx;
    next_rw = rw;
    next_ptr = ptr;
    next_wr_hi = wr_hi;
    next_rd_lsb = rd_lsb;
    next_tx_lsb = tx_lsb;
    next_sda_oe = sda_oe;
    reg_wr = 1'b0;
    wr_word = {wr_hi, shift};
    next_tout_cnt = (state == ST_IDLE || scl_rise || scl_fall) ? '0 : tout_cnt + 1'b1;
    if (start_det) begin
      next_state = ST_RX;
      next_bit_cnt = 4'h0;
      next_byte_idx = 2'b00;
      next_tx_lsb = 1'b0;
      next_sda_oe = 1'b0;
      next_tout_cnt = '0;
    end else if (stop_det || tout_hit) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt < 4'h8) begin
            next_shift = {shift[6:0], sda_s2};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (byte_idx == 2'b00 && shift[7:1] != DEV_ADDR) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_ACK;
              next_sda_oe = 1'b1;
              if (byte_idx == 2'b00) begin
                next_rw = shift[0];
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            next_state = ST_RX;
            unique case (byte_idx)
              2'b00: next_byte_idx = 2'b01;
              2'b01: begin
                next_ptr = shift;
                next_byte_idx = 2'b10;
              end
              2'b10: begin
                next_wr_hi = shift;
                next_byte_idx = 2'b11;
              end
              2'b11: begin
                reg_wr = 1'b1;
                next_byte_idx = 2'b10;
              end
            endcase
            if (byte_idx == 2'b00 && rw) begin
              // Word frozen at the high byte so the pair cannot tear
              next_state = ST_TX;
              next_shift = rd_word[15:8];
              next_rd_lsb = rd_word[7:0];
              next_sda_oe = !rd_word[15];
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              next_state = ST_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = !shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s2) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            // Reading on past the low byte starts the next word
            next_state = ST_TX;
            next_bit_cnt = 4'h0;
            next_tx_lsb = !tx_lsb;
            next_shift = tx_lsb ? rd_word[15:8] : rd_lsb;
            next_rd_lsb = tx_lsb ? rd_word[7:0] : rd_lsb;
            next_sda_oe = tx_lsb ? !rd_word[15] : !rd_lsb[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_idx <= 2'b00;
      rw <= 1'b0;
      ptr <= PTR_CONFIG;
      wr_hi <= 8'h00;
      rd_lsb <= 8'h00;
      tx_lsb <= 1'b0;
      sda_oe <= 1'b0;
      tout_cnt <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      byte_idx <= next_byte_idx;
      rw <= next_rw;
      ptr <= next_ptr;
      wr_hi <= next_wr_hi;
      rd_lsb <= next_rd_lsb;
      tx_lsb <= next_tx_lsb;
      sda_oe <= next_sda_oe;
      tout_cnt <= next_tout_cnt;
    end
  end

  // Register file; a soft reset bit restores defaults and drops calibration
  always_comb begin
    next_cfg = cfg;
    next_cal = cal;
    next_cal_valid = cal_valid;
    next_samp = conv_done_in ? sample_in : samp;
    if (reg_wr && ptr == PTR_CONFIG) begin
      next_cfg = wr_word;
      if (wr_word[15]) begin
        next_cfg = CONFIG_RESET;
        next_cal = CAL_RESET;
        next_cal_valid = 1'b0;
      end
    end else if (reg_wr && ptr == PTR_CAL) begin
      next_cal = wr_word;
      next_cal_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CONFIG_RESET;
      cal <= CAL_RESET;
      cal_valid <= 1'b0;
      samp <= '0;
    end else begin
      cfg <= next_cfg;
      cal <= next_cal;
      cal_valid <= next_cal_valid;
      samp <= next_samp;
    end
  end

  power_math u_math (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .start_in(conv_done_in),
    .cal_valid_in(cal_valid),
    .sample_in(sample_in),
    .cal_in(cal),
    .result_out(result_out),
    .done_out()
  );

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe;
  assign config_out = cfg;
  assign calibrated_out = cal_valid;

  uncal_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !cal_valid
      |=> result_out == '0)
    else $error("results not zero while uncalibrated");

  start_rx_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    start_det |=> state == ST_RX && bit_cnt == 4'h0 && byte_idx == 2'b00 && !sda_oe)
    else $error("start did not begin address reception");

  stop_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    stop_det && !start_det |=> state == ST_IDLE ##1 !sda_oe_out)
    else $error("stop did not end the transaction");

  addr_ack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    state == ST_RX && byte_idx == 2'b00 && bit_cnt == 4'h8 && scl_fall && !start_det
      && !stop_det && !tout_hit && shift[7:1] == DEV_ADDR
      |=> sda_oe_out && state == ST_ACK && rw == $past(shift[0]))
    else $error("matching address not acknowledged");

  stall_drop_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    tout_hit && !start_det |=> state == ST_IDLE && !sda_oe_out)
    else $error("stalled transaction not abandoned");

  ptr_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !(state == ST_ACK && byte_idx == 2'b01) |=> ptr == $past(ptr))
    else $error("pointer changed without a pointer write");

  msb_first_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    state == ST_ACK && scl_fall && rw && byte_idx == 2'b00 && !start_det && !stop_det
      && !tout_hit |=> state == ST_TX && shift == $past(rd_word[15:8]))
    else $error("read did not start with the high byte");

  cal_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    reg_wr && ptr == PTR_CAL |=> cal == $past(wr_word) && cal_valid ##1 state != ST_ACK)
    else $error("calibration write not loaded");

endmodule // current_power_calc_engine

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/1ns
module i2c_master_model (
  // Bench clock, used for phase only
  input wire logic clk_in,
  // Wire level
  input wire logic sda_in,
  // Driven lines
  output logic scl_out,
  output logic sda_oe_out,
  // Read result
  output logic [15:0] word_out,
  output logic word_stb_out
);
  logic ack_all;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    word_out = 16'h0000;
    word_stb_out = 1'b0;
    ack_all = 1'b0;
  end

  // Only this side makes clock, START and STOP
  // Steps are multiples of 5 ns from 2 ns past an edge, so no pin moves on a sampling edge
  task automatic start_c();
    @(posedge clk_in);
    #17 sda_oe_out = 1'b0;
    #45 scl_out = 1'b1;
    #60 sda_oe_out = 1'b1;
    #60 scl_out = 1'b0;
  endtask

  task automatic stop_c();
    @(posedge clk_in);
    #17 sda_oe_out = 1'b1;
    #45 scl_out = 1'b1;
    #60 sda_oe_out = 1'b0;
    #60;
  endtask

  // Data moves only while the clock is low
  task automatic bit_c(input logic b, output logic s);
    #15 sda_oe_out = ~b;
    #45 scl_out = 1'b1;
    #35 s = sda_in;
    #30 scl_out = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(~mack, s);
  endtask

  task automatic write_word(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v);
    logic k;
    ack_all = 1'b1;
    start_c();
    write_byte({a, 1'b0}, k);
    ack_all &= k;
    write_byte(p, k);
    ack_all &= k;
    write_byte(v[15:8], k);
    ack_all &= k;
    write_byte(v[7:0], k);
    ack_all &= k;
    stop_c();
  endtask

  // Pointer stage optional; the slave keeps the last one
  task automatic read_word(input logic [6:0] a, input logic [7:0] p, input logic setp);
    logic k;
    logic [7:0] hi;
    logic [7:0] lo;
    ack_all = 1'b1;
    if (setp) begin
      start_c();
      write_byte({a, 1'b0}, k);
      ack_all &= k;
      write_byte(p, k);
      ack_all &= k;
    end
    start_c();
    write_byte({a, 1'b1}, k);
    ack_all &= k;
    read_byte(1'b1, hi);
    read_byte(1'b0, lo);
    stop_c();
    word_out = {hi, lo};
    word_stb_out = 1'b1;
    #1 word_stb_out = 1'b0;
  endtask
endmodule // i2c_master_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import cpe_pkg::*;
  localparam int TO_CYC = 2000;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic conv_done = 1'b0;
  sample_s sample = '0;
  logic scl, sda, m_oe, d_sda, d_oe, m_stb, cal_ok, k;
  logic [15:0] m_word, cal, cur, pw, bu;
  logic signed [15:0] sh;
  config_s cfg;
  result_s res;
  int fails = 0;
  int n_checks = 0;
  int seed = 62308;
  int cyc = 0;
  real i_step;
  logic [15:0] exp_q[$];

  // Open-drain wire with pull-up
  assign sda = ~(m_oe | (d_oe & ~d_sda));
  always #5 core_clk = ~core_clk;

  i2c_master_model i_master (.clk_in(core_clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe),
    .word_out(m_word), .word_stb_out(m_stb));
  current_power_calc_engine #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (
    .core_clk_in(core_clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_out(d_oe), .sample_in(sample), .conv_done_in(conv_done),
    .config_out(cfg), .result_out(res), .calibrated_out(cal_ok));

  function automatic logic [15:0] exp_cur(logic signed [15:0] s, logic [15:0] c);
    longint p;
    p = longint'(s) * longint'(c);
    return 16'(p / 4096);
  endfunction

  function automatic logic [15:0] exp_pwr(logic [15:0] c, logic [15:0] b);
    longint m;
    m = longint'($signed(c));
    if (m < 0) m = -m;
    return 16'((m * longint'(b >> 3)) / 5000);
  endfunction

  task automatic check_w(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_b(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] p, input logic [15:0] e, input logic setp = 1'b1);
    exp_q.push_back(e);
    i_master.read_word(DEV_ADDR_DEFAULT, p, setp);
    check_b("read ack", 1'b1, i_master.ack_all);
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_master.write_word(DEV_ADDR_DEFAULT, p, v);
    check_b("write ack", 1'b1, i_master.ack_all);
  endtask

  task automatic conv(input logic signed [15:0] s, input logic [15:0] b);
    @(posedge core_clk);
    sample <= {s, b};
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Oldest expected word against each finished read
  always @(posedge m_stb) begin
    check_w("read word", (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx, m_word);
  end

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(PTR_CONFIG, CONFIG_RESET);
    conv(16'sh0100, 16'h2000);
    rd(PTR_CURRENT, 16'h0000);
    rd(PTR_POWER, 16'h0000);
    $display("Test defaults done");
    for (int i = 0; i < 6; i++) begin
      cal = 16'($random(seed)) & 16'h0fff;
      sh = 16'($random(seed));
      bu = 16'($random(seed));
      wr(PTR_CAL, cal);
      check_b("calibrated", 1'b1, cal_ok);
      conv(sh, bu);
      cur = exp_cur(sh, cal);
      pw = exp_pwr(cur, bu);
      check_w("result current", cur, res.current);
      check_w("result power", pw, res.power);
      rd(PTR_CURRENT, cur);
      rd(PTR_POWER, pw);
      rd(PTR_BUS, bu);
    end
    // Pointer still selects the bus register from the last read
    rd(PTR_BUS, bu, 1'b0);
    $display("Test scaling done");
    wr(PTR_POWER, 16'hffff);
    rd(PTR_POWER, pw);
    rd(8'h07, 16'h0000);
    i_master.write_word(7'h41, PTR_CAL, 16'h1234);
    check_b("foreign address ack", 1'b0, i_master.ack_all);
    v_cfg();
    $display("Test refusals done");
    wr(PTR_CAL, 16'h1000);
    conv(16'sh0010, 16'h0800);
    rd(PTR_CURRENT, 16'h0010);
    i_master.start_c();
    i_master.write_byte({DEV_ADDR_DEFAULT, 1'b1}, k);
    #100 check_b("slave drives", 1'b1, d_oe);
    #((TO_CYC + 300) * 10) check_b("bus released", 1'b0, d_oe);
    i_master.stop_c();
    rd(PTR_CURRENT, 16'h0010, 1'b0);
    $display("Test timeout done");
    // Host scaling: 0.125 ohm shunt, 3.2 A over 2^15 rounded up to a power of two
    i_step = 0.0001220703125;
    cal = 16'($rtoi(0.04096 / (i_step * 0.125)));
    wr(PTR_CAL, cal);
    conv(16'sd1000, 16'h6000);
    cur = exp_cur(16'sd1000, cal);
    rd(PTR_CURRENT, cur);
    // Ammeter reads 0.082 A against the reported current
    cal = 16'($rtoi(real'(cal) * 0.082 / (real'(cur) * i_step)));
    wr(PTR_CAL, cal);
    conv(16'sd1000, 16'h6000);
    rd(PTR_CURRENT, exp_cur(16'sd1000, cal));
    $display("Test host calibration done");
    wr(PTR_CONFIG, 16'h8000);
    check_b("calibrated", 1'b0, cal_ok);
    conv(16'sh0400, 16'h4000);
    rd(PTR_CURRENT, 16'h0000);
    rd(PTR_CONFIG, CONFIG_RESET);
    $display("Test soft reset done");
    complete_run();
  end

  // Config write, readback and port view
  task automatic v_cfg();
    logic [15:0] c;
    c = 16'($random(seed)) & 16'h7fff;
    wr(PTR_CONFIG, c);
    rd(PTR_CONFIG, c);
    check_w("config port", c, cfg);
  endtask
endmodule // tb_top
